// ===== common/fcd_params.svh
`ifndef FCD_PARAMS_SVH
`define FCD_PARAMS_SVH

// Register window decode
`define FCD_ADDR_W      8
`define FCD_PAGE_LSB    6
`define FCD_CH_LSB      4
`define FCD_REG_LSB     2
`define FCD_REG_SRC     2'h0
`define FCD_REG_DST     2'h1
`define FCD_REG_RLD     2'h2
`define FCD_REG_CTL     2'h3

// Control word fields
`define FCD_CTL_EN      0
`define FCD_CTL_REQ     1
`define FCD_CTL_WORD    2
`define FCD_CTL_RPT     3
`define FCD_CTL_SFWD    4
`define FCD_CTL_DFWD    5
`define FCD_CTL_SWT     6
`define FCD_CTL_CSEL_LO 8
`define FCD_CTL_CSEL_HI 11
`define FCD_CTL_CNT_LO  16
`define FCD_CTL_CNT_HI  31

// Address ranges the channels must never reach
`define FCD_OWN0_LO     20'h00020
`define FCD_OWN0_HI     20'h0003f
`define FCD_OWN1_LO     20'h00180
`define FCD_OWN1_HI     20'h0019f

// Widths and reset values
`define FCD_PER_W       8
`define FCD_RST_PTR     20'h00000
`define FCD_RST_CNT     16'h0000

`endif

// ===== common/fcd_pkg.sv
package fcd_pkg;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READ,
      ST_CAPT,
      ST_WRITE,
      ST_GAP
   } fcd_state_t;

   typedef struct packed {
      fcd_state_t       st;
      logic [3:0][19:0] src;
      logic [3:0][19:0] dst;
      logic [3:0][19:0] fwd;
      logic [3:0][15:0] rld;
      logic [3:0][15:0] cnt;
      logic [3:0][3:0]  csel;
      logic [3:0]       en;
      logic [3:0]       req;
      logic [3:0]       word;
      logic [3:0]       rpt;
      logic [3:0]       sfwd;
      logic [3:0]       dfwd;
      logic [3:0]       fresh;
      logic [3:0]       done;
      logic [3:0]       irq;
      logic [1:0]       cur;
      logic             hold;
      logic             rd;
      logic             wr;
      logic             wsz;
      logic [19:0]      addr;
      logic [15:0]      wdata;
      logic [31:0]      rdata;
   } fcd_regs_t;

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] fall;
      logic [2:0] both;
   } fcd_sync_t;

endpackage

// ===== hw/fcd_edge_sync.sv
`timescale 1ns/1ps
`default_nettype none

module fcd_edge_sync
   import fcd_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk_in,
   input  wire logic       rst_n_in,
   // External pins
   input  wire logic [2:0] ext_irq_in,
   // Edge pulses
   output logic [2:0]      fall_out,
   output logic [2:0]      both_out
);

   fcd_sync_t r;
   fcd_sync_t n;

   always_comb begin
      n = r;
      n.s1 = ext_irq_in;
      n.s2 = r.s1;
      n.s3 = r.s2;
      n.fall = r.s3 & ~r.s2;
      n.both = r.s3 ^ r.s2;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         // Pins keep shifting in during reset so release brings no false edge
         r <= '{s1: n.s1, s2: n.s2, s3: n.s3, fall: 3'h0, both: 3'h0};
      end else begin
         r <= n;
      end
   end

   assign fall_out = r.fall;
   assign both_out = r.both;

endmodule

`default_nettype wire

// ===== hw/fcd_core.sv
// Overview of operation
// - Four independent channels, each moving data by stealing shared bus cycles.
// - A pending transfer takes the bus ahead of the processor.
// - Each request moves exactly one unit, word or byte per channel.
// - Requests ignore processor interrupt masking; transfers leave interrupt state alone.
// - Each channel selects its request cause from pins, peripherals, software, channels.
// - Simultaneous requests are served channel zero first, then one, two, three.
// - Transfers run variable to fixed, fixed to variable, or fixed to fixed.
// - Channel accesses can never reach the controller's own register ranges.
// - Counter allows up to 65536 units per run.
// - Enabled channel transfers on each request; disabled channel stays inactive.
// - Single mode: counter underflow clears enable and stops the channel.
// - Repeat mode: underflow reloads counter and forward pointer, stays active.
// - Channel interrupt request pulses when its counter underflows, both modes.
// - First transfer after activation loads forward pointer and counter.
// - Forward pointer always writable; fixed pointer writable only while disabled, except a destination whose forward bit is set along with the source's.
// - Registers always readable; enabled forward pointer reads the live address.
// - Requests faster than transfers collapse into one pending bit.
// - Request bit sets on any request, clears before transfer, software clears only.
// - Writing enable one to an active channel restarts it from initial state.
// - After each transfer the processor gets the bus before the next channel.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fcd_params.svh"

module fcd_core
   import fcd_pkg::*;
(
   // Clock and reset
   input  wire logic                  ref_clk_in,
   input  wire logic                  rst_n_in,
   // Register port
   input  wire logic [`FCD_ADDR_W-1:0] reg_addr_in,
   input  wire logic [31:0]           reg_wdata_in,
   input  wire logic                  reg_wr_in,
   input  wire logic                  reg_rd_in,
   output logic [31:0]                reg_rdata_out,
   // Request sources
   input  wire logic [2:0]            ext_irq_in,
   input  wire logic [`FCD_PER_W-1:0] periph_req_in,
   // Shared bus
   input  wire logic [15:0]           mem_rdata_in,
   output logic                       cpu_hold_out,
   output logic [19:0]                mem_addr_out,
   output logic                       mem_rd_out,
   output logic                       mem_wr_out,
   output logic                       mem_word_out,
   output logic [15:0]                mem_wdata_out,
   // Channel interrupt requests
   output logic [3:0]                 irq_out
);

   fcd_regs_t  r;
   fcd_regs_t  n;
   logic [2:0] ext_fall;
   logic [2:0] ext_both;
   logic [3:0] trig;
   logic [3:0] elig;
   logic [3:0] sw_trig;
   logic [1:0] sel;
   logic       start;
   logic       fin;
   logic       page_hit;
   logic [1:0] acc_ch;
   logic [1:0] acc_reg;
   logic [19:0] fa;
   logic [19:0] sa;
   logic [19:0] da;

   fcd_edge_sync u_sync (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .ext_irq_in (ext_irq_in),
      .fall_out   (ext_fall),
      .both_out   (ext_both)
   );

   function automatic logic fcd_own(input logic [19:0] a);
      fcd_own = (a >= `FCD_OWN0_LO && a <= `FCD_OWN0_HI) ||
                (a >= `FCD_OWN1_LO && a <= `FCD_OWN1_HI);
   endfunction

   function automatic logic fcd_hit(input logic [3:0] cs,
                                    input logic sw,
                                    input logic [2:0] fall,
                                    input logic [2:0] both,
                                    input logic other,
                                    input logic [`FCD_PER_W-1:0] per);
      logic h;
      h = 1'b0;
      if (cs[3]) begin
         h = per[cs[2:0]];
      end else begin
         unique case (cs[2:0])
            3'h0: h = sw;
            3'h1: h = fall[0];
            3'h2: h = fall[1];
            3'h3: h = fall[2];
            3'h4: h = both[0];
            3'h5: h = both[1];
            3'h6: h = both[2];
            3'h7: h = other;
         endcase
      end
      fcd_hit = h;
   endfunction

   assign page_hit = (reg_addr_in[`FCD_ADDR_W-1:`FCD_PAGE_LSB] == 2'h0);
   assign acc_ch   = reg_addr_in[`FCD_CH_LSB+1:`FCD_CH_LSB];
   assign acc_reg  = reg_addr_in[`FCD_REG_LSB+1:`FCD_REG_LSB];

   always_comb begin
      n = r;
      n.irq = 4'h0;
      n.done = 4'h0;
      n.rd = 1'b0;
      n.wr = 1'b0;
      n.rdata = 32'h0;
      sel = 2'h0;
      start = 1'b0;
      fin = 1'b0;
      fa = `FCD_RST_PTR;
      sa = `FCD_RST_PTR;
      da = `FCD_RST_PTR;

      // only enable and request steer a start, no interrupt masking
      elig = r.en & r.req;
      for (int i = 3; i >= 0; i--) begin
         if (elig[i]) begin
            sel = 2'(i);
         end
      end

      unique case (r.st)
         ST_IDLE: begin
            // claim the bus as soon as a channel is due
            if (elig != 4'h0) begin
               start = 1'b1;
               n.cur = sel;
               // request bit drops as the transfer begins
               n.req[sel] = 1'b0;
               fa = r.fwd[sel];
               // first transfer loads pointer and counter
               if (r.fresh[sel]) begin
                  fa = r.sfwd[sel] ? r.src[sel] : r.dst[sel];
                  n.fwd[sel] = fa;
                  n.cnt[sel] = r.rld[sel];
                  n.fresh[sel] = 1'b0;
               end
               // forward side uses the moving pointer, the other stays put
               sa = r.sfwd[sel] ? fa : r.src[sel];
               n.addr = sa;
               // no strobe into the protected windows
               n.rd = !fcd_own(sa);
               // one unit of the channel's size
               n.wsz = r.word[sel];
               n.hold = 1'b1;
               n.st = ST_READ;
            end
         end
         ST_READ: begin
            n.st = ST_CAPT;
         end
         ST_CAPT: begin
            // with both sides marked forward only the source moves
            da = (r.dfwd[r.cur] && !r.sfwd[r.cur]) ? r.fwd[r.cur] : r.dst[r.cur];
            n.addr = da;
            // no strobe into the protected windows
            n.wr = !fcd_own(da);
            n.wdata = r.word[r.cur] ? mem_rdata_in : {8'h00, mem_rdata_in[7:0]};
            n.st = ST_WRITE;
         end
         ST_WRITE: begin
            fin = 1'b1;
            // release the bus for one processor access
            n.hold = 1'b0;
            n.done[r.cur] = 1'b1;
            if (r.sfwd[r.cur] || r.dfwd[r.cur]) begin
               n.fwd[r.cur] = r.fwd[r.cur] + {18'h0, r.word[r.cur], ~r.word[r.cur]};
            end
            // zero count still moves one unit, so 65536 units per run
            if (r.cnt[r.cur] == 16'h0000) begin
               n.irq[r.cur] = 1'b1;
               if (r.rpt[r.cur]) begin
                  // reload on the next transfer, remain enabled
                  n.fresh[r.cur] = 1'b1;
               end else begin
                  n.en[r.cur] = 1'b0;
               end
            end else begin
               n.cnt[r.cur] = r.cnt[r.cur] - 16'h0001;
            end
            n.st = ST_GAP;
         end
         ST_GAP: begin
            n.st = ST_IDLE;
         end
         default: begin
            n.st = ST_IDLE;
         end
      endcase

      // Register writes come after the engine so software wins a same-cycle race
      sw_trig = 4'h0;
      for (int i = 0; i < 4; i++) begin
         if (reg_wr_in && page_hit && acc_ch == 2'(i)) begin
            unique case (acc_reg)
               `FCD_REG_SRC: begin
                  if (r.sfwd[i] || !r.en[i]) begin
                     n.src[i] = reg_wdata_in[19:0];
                  end
               end
               `FCD_REG_DST: begin
                  if (r.dfwd[i] || !r.en[i]) begin
                     n.dst[i] = reg_wdata_in[19:0];
                  end
               end
               `FCD_REG_RLD: begin
                  n.rld[i] = reg_wdata_in[15:0];
               end
               `FCD_REG_CTL: begin
                  n.en[i] = reg_wdata_in[`FCD_CTL_EN];
                  // enable written to one restarts from the initial state
                  if (reg_wdata_in[`FCD_CTL_EN]) begin
                     n.fresh[i] = 1'b1;
                  end
                  n.word[i] = reg_wdata_in[`FCD_CTL_WORD];
                  n.rpt[i] = reg_wdata_in[`FCD_CTL_RPT];
                  n.sfwd[i] = reg_wdata_in[`FCD_CTL_SFWD];
                  n.dfwd[i] = reg_wdata_in[`FCD_CTL_DFWD];
                  n.csel[i] = reg_wdata_in[`FCD_CTL_CSEL_HI:`FCD_CTL_CSEL_LO];
                  // software may clear but never set
                  if (!reg_wdata_in[`FCD_CTL_REQ]) begin
                     n.req[i] = 1'b0;
                  end
                  sw_trig[i] = reg_wdata_in[`FCD_CTL_SWT];
               end
            endcase
         end
      end

      // a request sets the bit whatever the enable, and beats any clear
      for (int i = 0; i < 4; i++) begin
         trig[i] = fcd_hit(r.csel[i], sw_trig[i], ext_fall, ext_both,
                           r.done[(i + 3) % 4], periph_req_in);
         // one pending bit, extra requests merge
         if (trig[i]) begin
            n.req[i] = 1'b1;
         end
      end

      // readable at any time, live pointer while enabled
      if (reg_rd_in && page_hit) begin
         unique case (acc_reg)
            `FCD_REG_SRC: n.rdata = {12'h000, (r.en[acc_ch] && r.sfwd[acc_ch]) ?
                                     r.fwd[acc_ch] : r.src[acc_ch]};
            `FCD_REG_DST: n.rdata = {12'h000, (r.en[acc_ch] && r.dfwd[acc_ch] &&
                                     !r.sfwd[acc_ch]) ? r.fwd[acc_ch] : r.dst[acc_ch]};
            `FCD_REG_RLD: n.rdata = {16'h0000, r.rld[acc_ch]};
            `FCD_REG_CTL: n.rdata = {r.cnt[acc_ch], 4'h0, r.csel[acc_ch], 2'h0,
                                     r.dfwd[acc_ch], r.sfwd[acc_ch], r.rpt[acc_ch],
                                     r.word[acc_ch], r.req[acc_ch], r.en[acc_ch]};
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign reg_rdata_out = r.rdata;
   assign cpu_hold_out  = r.hold;
   assign mem_addr_out  = r.addr;
   assign mem_rd_out    = r.rd;
   assign mem_wr_out    = r.wr;
   assign mem_word_out  = r.wsz;
   assign mem_wdata_out = r.wdata;
   assign irq_out       = r.irq;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   sequence s_move;
      r.st == ST_READ ##1 r.st == ST_CAPT ##1 r.st == ST_WRITE;
   endsequence

   sequence s_back;
      r.st == ST_GAP ##1 r.st == ST_IDLE;
   endsequence

   a_unit_sequence: assert property (start |=> s_move ##1 s_back)
      else $error("transfer did not run read, write and gap in order");

   a_bus_steal: assert property (start |=> cpu_hold_out [*3] ##1 !cpu_hold_out)
      else $error("bus not held for exactly the transfer");

   a_cpu_gap: assert property (fin |=> !cpu_hold_out ##1 !cpu_hold_out)
      else $error("next transfer started without a processor slot");

   a_prio_pick: assert property (start && elig[0] |-> sel == 2'h0)
      else $error("channel zero not served first");

   a_own_block: assert property ((mem_rd_out || mem_wr_out) |-> !fcd_own(mem_addr_out))
      else $error("strobe into protected register window");

   a_start_enabled: assert property (start |-> r.en[sel] && r.req[sel])
      else $error("transfer started on an idle channel");

   a_single_stop: assert property (fin && r.cnt[r.cur] == 16'h0 && !r.rpt[r.cur] &&
                                   !reg_wr_in |=> !r.en[$past(r.cur)])
      else $error("single mode channel still enabled after underflow");

   a_repeat_reload: assert property (fin && r.cnt[r.cur] == 16'h0 && r.rpt[r.cur]
                                     |=> r.fresh[$past(r.cur)] && r.en[$past(r.cur)])
      else $error("repeat mode did not arm reload");

   a_irq_underflow: assert property (irq_out != 4'h0 |-> $past(fin) &&
                                     $past(r.cnt[r.cur]) == 16'h0)
      else $error("interrupt without counter underflow");

   a_req_set: assert property (trig[1] |=> r.req[1])
      else $error("request lost on arrival");

   a_req_clear: assert property (start |=> !r.req[$past(sel)] || $past(trig[sel]))
      else $error("request bit not cleared at transfer start");

   a_byte_upper: assert property (mem_wr_out && !mem_word_out |-> mem_wdata_out[15:8] == 8'h00)
      else $error("byte transfer drives upper data byte");

endmodule

`default_nettype wire

// ===== dv/fcd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module fcd_mem_model (
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        rst_n_in,
   // Bus from the controller
   input  wire logic [19:0] mem_addr_in,
   input  wire logic        mem_rd_in,
   // Read data back
   output logic      [15:0] mem_rdata_out
);
   // Answer a read one cycle later; between reads the lines keep toggling
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         mem_rdata_out <= 16'h0000;
      end else if (mem_rd_in) begin
         mem_rdata_out <= mem_addr_in[15:0] ^ 16'h5a3c;
      end else begin
         mem_rdata_out <= ~mem_rdata_out;
      end
   end
endmodule

`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic        clk, rst_n, wr, rd, hold, mrd, mwr, mword;
   logic [7:0]  addr, per;
   logic [31:0] wdata, rdata, v;
   logic [2:0]  ext;
   logic [15:0] mdata, mwd, rnd;
   logic [19:0] maddr, s, d;
   logic [3:0]  irq;
   logic [36:0] wq[$];
   int          num_errors, n_tests, gap_bad, hold_bad, ic[4];
   bit          low_seen;

   fcd_core i_fcd_core (.ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .ext_irq_in(ext), .periph_req_in(per),
      .mem_rdata_in(mdata), .cpu_hold_out(hold), .mem_addr_out(maddr), .mem_rd_out(mrd),
      .mem_wr_out(mwr), .mem_word_out(mword), .mem_wdata_out(mwd), .irq_out(irq));
   fcd_mem_model i_fcd_mem_model (.ref_clk_in(clk), .rst_n_in(rst_n), .mem_addr_in(maddr),
      .mem_rd_in(mrd), .mem_rdata_out(mdata));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Log bus writes, interrupt pulses and the CPU slot between transfers
   always @(posedge clk) begin
      if (mwr === 1'b1) wq.push_back({mword, mwd, maddr});
      if ((mrd === 1'b1 || mwr === 1'b1) && hold !== 1'b1) hold_bad++;
      for (int c = 0; c < 4; c++) if (irq[c] === 1'b1) ic[c]++;
      if (mrd === 1'b1) begin
         if (!low_seen) gap_bad++;
         low_seen = 1'b0;
      end
      if (hold === 1'b0) low_seen = 1'b1;
   end

   function automatic logic [15:0] nxt();
      rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      return rnd;
   endfunction

   function automatic logic [15:0] dat(input logic [19:0] a, input logic w);
      logic [15:0] x;
      x = a[15:0] ^ 16'h5a3c;
      return w ? x : {8'h00, x[7:0]};
   endfunction

   function automatic logic [7:0] ra(input int c, input int r);
      return 8'(c * 16 + r * 4);
   endfunction

   task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] x);
      @(posedge clk);
      addr <= a;
      wdata <= x;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [7:0] a, output logic [31:0] x);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 x = rdata;
   endtask

   task automatic cfg(input int c, input logic [19:0] sa, input logic [19:0] da, input logic [15:0] n,
                      input logic [31:0] ctl);
      // callers never set both forward bits
      wreg(ra(c, 0), {12'h000, sa});
      wreg(ra(c, 1), {12'h000, da});
      wreg(ra(c, 2), {16'h0000, n});
      wreg(ra(c, 3), ctl);
   endtask

   task automatic pulse(input int i);
      @(posedge clk);
      per[i] <= 1'b1;
      @(posedge clk);
      per <= 8'h00;
   endtask

   task automatic exp_wr(input logic [19:0] a, input logic [15:0] x, input logic w);
      for (int k = 0; k < 40 && wq.size() == 0; k++) @(posedge clk);
      if (wq.size() == 0) chk("bus write", 40'h1, 40'h0);
      else chk("bus write", {3'h0, w, x, a}, {3'h0, wq.pop_front()});
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      wrap_up();
   end

   initial begin
      {rst_n, wr, rd, per, addr, wdata} = '0;
      ext = 3'b111;
      rnd = 16'd55432;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rreg(ra(0, 3), v); chk("ctl reset", 40'h0, v);
      rreg(8'h40, v); chk("unmapped", 40'h0, {8'h0, v});
      // Single mode, byte units, forward source
      s = {4'h1, nxt()};
      cfg(0, s, 20'h08000, 16'h0002, 32'h0811);
      for (int i = 0; i < 3; i++) begin
         pulse(0);
         exp_wr(20'h08000, dat(s + 20'(i), 1'b0), 1'b0);
      end
      repeat (4) @(posedge clk);
      chk("irq ch0", 40'd1, 40'(ic[0]));
      rreg(ra(0, 3), v); chk("enable ch0", 40'h0, {39'h0, v[0]});
      pulse(0);
      repeat (12) @(posedge clk);
      chk("idle bus", 40'h0, 40'(wq.size()));
      rreg(ra(0, 3), v); chk("request set", 40'h1, {39'h0, v[1]});
      wreg(ra(0, 3), 32'h0800);
      rreg(ra(0, 3), v); chk("request clr", 40'h0, {39'h0, v[1]});
      // Repeat mode, word units, forward destination, restart
      s = {4'h2, nxt()};
      d = 20'h20000;
      cfg(1, s, d, 16'h0001, 32'h092d);
      wreg(ra(1, 0), {12'h000, s ^ 20'h00ff0});
      rreg(ra(1, 0), v); chk("fixed ptr", {20'h0, s}, {8'h0, v});
      pulse(1); exp_wr(d, dat(s, 1'b1), 1'b1);
      rreg(ra(1, 1), v); chk("live ptr", {20'h0, d + 20'h2}, {8'h0, v});
      pulse(1); exp_wr(d + 20'h2, dat(s, 1'b1), 1'b1);
      pulse(1); exp_wr(d, dat(s, 1'b1), 1'b1);
      wreg(ra(1, 3), 32'h092d);
      pulse(1); exp_wr(d, dat(s, 1'b1), 1'b1);
      repeat (4) @(posedge clk);
      chk("irq ch1", 40'd1, 40'(ic[1]));
      rreg(ra(1, 3), v); chk("enable ch1", 40'h1, {39'h0, v[0]});
      wreg(ra(1, 3), 32'h0900);
      // One request for all channels, one destination inside the own range
      s = {4'h4, nxt()};
      for (int c = 0; c < 4; c++) cfg(c, s, (c == 3) ? 20'h00180 : 20'h30000 + 20'(c * 16), 16'h0, 32'h0a01);
      pulse(2);
      for (int c = 0; c < 3; c++) exp_wr(20'h30000 + 20'(c * 16), dat(s, 1'b0), 1'b0);
      repeat (20) @(posedge clk);
      chk("own range", 40'h0, 40'(wq.size()));
      chk("irq ch3", 40'd1, 40'(ic[3]));
      chk("cpu slot", 40'h0, 40'(gap_bad));
      // Falling edge on pin zero
      s = {4'h5, nxt()};
      cfg(2, s, 20'h50000, 16'h0, 32'h0101);
      @(posedge clk);
      ext <= 3'b110;
      exp_wr(20'h50000, dat(s, 1'b0), 1'b0);
      // Both edges on pin zero: the rising edge triggers channel three
      cfg(3, s, 20'h52000, 16'h0, 32'h0401);
      @(posedge clk);
      ext <= 3'b111;
      exp_wr(20'h52000, dat(s, 1'b0), 1'b0);
      // Two software triggers while disabled merge; channel one chains on channel zero
      s = {4'h6, nxt()};
      cfg(0, s, 20'h60000, 16'h1, 32'h0000);
      cfg(1, s, 20'h61000, 16'h0, 32'h0701);
      wreg(ra(0, 3), 32'h0040);
      wreg(ra(0, 3), 32'h0040);
      wreg(ra(0, 3), 32'h0003);
      exp_wr(20'h60000, dat(s, 1'b0), 1'b0);
      exp_wr(20'h61000, dat(s, 1'b0), 1'b0);
      repeat (20) @(posedge clk);
      chk("merged requests", 40'h0, 40'(wq.size()));
      chk("hold on strobe", 40'h0, 40'(hold_bad));
      // Reset in mid-run clears the live channel
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      rreg(ra(0, 3), v); chk("ctl mid reset", 40'h0, {8'h0, v});
      wrap_up();
   end
endmodule

`default_nettype wire
